// File: shared/misc_regs_pkg.sv
// Package for the timer, free-running counter and soft reset block.
// Assumes a register port with byte address, write strobe and data.
package misc_regs_pkg;

  // ****************************************************************
  // Register offsets (byte addresses)
  // ****************************************************************
  localparam logic [11:0] TIMER_CONFIG_OFS       = 12'h08C;
  localparam logic [11:0] TIMER_COUNT_VALUE_OFS  = 12'h090;
  localparam logic [11:0] TICK_COUNTER_25MHZ_OFS = 12'h09C;
  localparam logic [11:0] SOFT_RESET_CONTROL_OFS = 12'h1F8;

  // ****************************************************************
  // Field positions and reset values
  // ****************************************************************
  localparam int          TIMER_EN_BIT        = 29;
  localparam int          VIRTUAL_PHY_RST_BIT = 3;
  localparam int          PORT2_PHY_RST_BIT   = 2;
  localparam int          PORT1_PHY_RST_BIT   = 1;
  localparam logic [15:0] PRELOAD_RESET       = 16'hFFFF;
  localparam logic [15:0] COUNT_RESET         = 16'hFFFF;
  localparam logic [31:0] TICK_RESET          = 32'h00000000;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLK_MHZ          = 125;
  localparam int TICK_MHZ         = 25;
  // Clock cycles per 25 MHz tick
  localparam int TICK_DIV         = CLK_MHZ / TICK_MHZ;
  // Least PHY reset hold time in microseconds
  localparam int PHY_HOLD_US      = 102;
  // Least hold in cycles, rounded up
  localparam int PHY_HOLD_CYCLES  = PHY_HOLD_US * CLK_MHZ;
  // Longest time for the tick counter to clear after reset
  localparam int TICK_CLEAR_NS    = 160;
  // Virtual PHY reset pulse length in cycles
  localparam int VPHY_HOLD_CYCLES = 4;

  // ****************************************************************
  // Register access carrier
  // ****************************************************************
  typedef struct packed {
    logic        rd;
    logic        wr;
    logic        from_loader;
    logic [11:0] addr;
    logic [3:0]  be;
    logic [31:0] wdata;
  } reg_req_type;

endpackage

// File: logic/phy_reset_hold.sv
// Self-clearing reset hold for one PHY: a request starts a timed reset.
// Assumes requests come from logic on the same clock.
`timescale 1ns/1ps
`default_nettype none
module phy_reset_hold #(
  parameter int HOLD_CYCLES = 12750
) (
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic arst_n_i,
  // Control
  input  wire logic start_i,
  output logic      busy_o
);

  localparam int CW = $clog2(HOLD_CYCLES + 1);

  logic [CW-1:0] count_ff;
  logic          busy_ff;

  // Hold busy for HOLD_CYCLES cycles, then drop it; start ignored while busy
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      busy_ff  <= 1'b0;
      count_ff <= '0;
    end else if (!busy_ff) begin
      if (start_i) begin
        busy_ff  <= 1'b1;
        count_ff <= CW'(HOLD_CYCLES - 1);
      end
    end else if (count_ff == '0) begin
      busy_ff <= 1'b0;
    end else begin
      count_ff <= count_ff - 1'b1;
    end
  end

  assign busy_o = busy_ff;

endmodule
`default_nettype wire

// File: logic/gp_timer_freerun_soft_reset_control.sv
// Timer, free-running tick counter and PHY soft reset registers.
// Assumes a single-cycle register port on clk_i; reads answer next cycle.
`timescale 1ns/1ps
`default_nettype none
module gp_timer_freerun_soft_reset_control #(
  parameter int PHY_HOLD = misc_regs_pkg::PHY_HOLD_CYCLES
) (
  // Clock and reset
  input  wire logic                       clk_i,
  input  wire logic                       arst_n_i,
  // Register port
  input  wire misc_regs_pkg::reg_req_type req_i,
  output logic [31:0]                     rdata_o,
  output logic                            rvalid_o,
  // Timer event
  output logic                            timer_irq_o,
  // PHY resets
  output logic                            virtual_phy_reset_o,
  output logic                            port2_phy_reset_o,
  output logic                            port1_phy_reset_o
);

  // ****************************************************************
  // Decode
  // ****************************************************************
  logic wr_cfg;
  logic wr_rst;
  logic host_rst_wr;

  assign wr_cfg = req_i.wr && req_i.addr == misc_regs_pkg::TIMER_CONFIG_OFS;
  assign wr_rst = req_i.wr &&
                  req_i.addr == misc_regs_pkg::SOFT_RESET_CONTROL_OFS;
  assign host_rst_wr = wr_rst && !req_i.from_loader && req_i.be[0];

  // ****************************************************************
  // General timer
  // ****************************************************************
  logic        timer_en_ff;
  logic [15:0] timer_preload_ff;
  logic [15:0] timer_current_count_ff;
  logic        timer_irq_ff;
  logic        nxt_en;
  logic [15:0] nxt_preload;

  // Enable value after this cycle's write
  assign nxt_en = (wr_cfg && req_i.be[3]) ?
                  req_i.wdata[misc_regs_pkg::TIMER_EN_BIT] : timer_en_ff;

  // Preload as this cycle's write leaves it. A single write that sets the
  // enable and a new preload together must start from the new value, not
  // from whatever the preload held before the write.
  always_comb begin
    nxt_preload = timer_preload_ff;
    if (wr_cfg && req_i.be[0]) begin
      nxt_preload[7:0] = req_i.wdata[7:0];
    end
    if (wr_cfg && req_i.be[1]) begin
      nxt_preload[15:8] = req_i.wdata[15:8];
    end
  end

  // Enable bit
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      timer_en_ff <= 1'b0;
    end else begin
      timer_en_ff <= nxt_en;
    end
  end

  // Preload field; falling enable presets it
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      timer_preload_ff <= misc_regs_pkg::PRELOAD_RESET;
    end else if (timer_en_ff && !nxt_en) begin
      timer_preload_ff <= misc_regs_pkg::PRELOAD_RESET;
    end else if (wr_cfg) begin
      if (req_i.be[0]) begin
        timer_preload_ff[7:0] <= req_i.wdata[7:0];
      end
      if (req_i.be[1]) begin
        timer_preload_ff[15:8] <= req_i.wdata[15:8];
      end
    end
  end

  // Count: load on enable, decrement while running, reload on underflow
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      timer_current_count_ff <= misc_regs_pkg::COUNT_RESET;
    end else if (!timer_en_ff && nxt_en) begin
      timer_current_count_ff <= nxt_preload;
    end else if (timer_en_ff) begin
      if (timer_current_count_ff == 16'h0000) begin
        timer_current_count_ff <= timer_preload_ff;
      end else begin
        timer_current_count_ff <= timer_current_count_ff - 16'h0001;
      end
    end
  end

  // One-cycle event on each underflow
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      timer_irq_ff <= 1'b0;
    end else begin
      timer_irq_ff <= timer_en_ff &&
                      timer_current_count_ff == 16'h0000;
    end
  end

  assign timer_irq_o = timer_irq_ff;

  // ****************************************************************
  // Free-running tick counter
  // ****************************************************************
  localparam int DW = $clog2(misc_regs_pkg::TICK_DIV);

  logic [DW-1:0] div_ff;
  logic [31:0]   free_running_count_ff;

  // Divide 125 MHz down to a 25 MHz tick
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      div_ff <= '0;
    end else if (div_ff == DW'(misc_regs_pkg::TICK_DIV - 1)) begin
      div_ff <= '0;
    end else begin
      div_ff <= div_ff + 1'b1;
    end
  end

  // Clears at once on reset, well within the allowed delay
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      free_running_count_ff <= misc_regs_pkg::TICK_RESET;
    end else if (div_ff == DW'(misc_regs_pkg::TICK_DIV - 1)) begin
      free_running_count_ff <= free_running_count_ff + 32'h00000001;
    end
  end

  // ****************************************************************
  // PHY soft resets
  // ****************************************************************
  logic vphy_busy;
  logic p2_busy;
  logic p1_busy;

  // Writes only start a reset when idle; the hold blocks ignore busy starts.
  // Each output is the reset level itself, so a read of the control bit
  // shows exactly whether that PHY is still held.
  phy_reset_hold #(
    .HOLD_CYCLES (misc_regs_pkg::VPHY_HOLD_CYCLES)
  ) u_vphy (
    .clk_i    (clk_i),
    .arst_n_i (arst_n_i),
    .start_i  (host_rst_wr &&
               req_i.wdata[misc_regs_pkg::VIRTUAL_PHY_RST_BIT]),
    .busy_o   (vphy_busy)
  );

  phy_reset_hold #(
    .HOLD_CYCLES (PHY_HOLD)
  ) u_port2 (
    .clk_i    (clk_i),
    .arst_n_i (arst_n_i),
    .start_i  (host_rst_wr &&
               req_i.wdata[misc_regs_pkg::PORT2_PHY_RST_BIT]),
    .busy_o   (p2_busy)
  );

  phy_reset_hold #(
    .HOLD_CYCLES (PHY_HOLD)
  ) u_port1 (
    .clk_i    (clk_i),
    .arst_n_i (arst_n_i),
    .start_i  (host_rst_wr &&
               req_i.wdata[misc_regs_pkg::PORT1_PHY_RST_BIT]),
    .busy_o   (p1_busy)
  );

  assign virtual_phy_reset_o = vphy_busy;
  assign port2_phy_reset_o   = p2_busy;
  assign port1_phy_reset_o   = p1_busy;

  // ****************************************************************
  // Read path
  // ****************************************************************
  logic [31:0] nxt_rdata;
  logic [31:0] rdata_ff;
  logic        rvalid_ff;

  // Full word returned; a host may use either half alone, no side effects.
  // Reads never change state, so polling during a PHY reset is harmless.
  always_comb begin
    nxt_rdata = 32'h00000000;
    case (req_i.addr)
      misc_regs_pkg::TIMER_CONFIG_OFS: begin
        nxt_rdata[misc_regs_pkg::TIMER_EN_BIT] = timer_en_ff;
        nxt_rdata[15:0] = timer_preload_ff;
      end
      misc_regs_pkg::TIMER_COUNT_VALUE_OFS: begin
        nxt_rdata[15:0] = timer_current_count_ff;
      end
      misc_regs_pkg::TICK_COUNTER_25MHZ_OFS: begin
        nxt_rdata = free_running_count_ff;
      end
      misc_regs_pkg::SOFT_RESET_CONTROL_OFS: begin
        nxt_rdata[misc_regs_pkg::VIRTUAL_PHY_RST_BIT] = vphy_busy;
        nxt_rdata[misc_regs_pkg::PORT2_PHY_RST_BIT]   = p2_busy;
        nxt_rdata[misc_regs_pkg::PORT1_PHY_RST_BIT]   = p1_busy;
      end
      default: begin
        nxt_rdata = 32'h00000000;
      end
    endcase
  end

  // Registered read data, one cycle after the request
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rdata_ff  <= 32'h00000000;
      rvalid_ff <= 1'b0;
    end else begin
      rvalid_ff <= req_i.rd;
      if (req_i.rd) begin
        rdata_ff <= nxt_rdata;
      end
    end
  end

  assign rdata_o  = rdata_ff;
  assign rvalid_o = rvalid_ff;

endmodule
`default_nettype wire

// File: verification/misc_regs_checker.sv
// Port checker for the timer and soft reset register block.
// Assumes a bind to the block's top module, with PHY_HOLD handed on.
`timescale 1ns/1ps
`default_nettype none
module misc_regs_checker #(
  parameter int PHY_HOLD = 20
) (
  // Clock and reset
  input wire logic                       clk_i,
  input wire logic                       arst_n_i,
  // Register port
  input wire misc_regs_pkg::reg_req_type req_i,
  input wire logic [31:0]                rdata_o,
  input wire logic                       rvalid_o,
  // Outputs
  input wire logic                       timer_irq_o,
  input wire logic                       virtual_phy_reset_o,
  input wire logic                       port2_phy_reset_o,
  input wire logic                       port1_phy_reset_o
);
  logic [31:0] cnt2_ff;
  logic [31:0] cnt1_ff;
  logic        en_ff;
  // Host reset control write with bit 0 lane
  wire logic ctl_wr = req_i.wr && !req_i.from_loader && req_i.be[0] &&
    req_i.addr == misc_regs_pkg::SOFT_RESET_CONTROL_OFS;
  // Cycles the port 2 and port 1 PHY resets have stood high
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cnt2_ff <= 32'h0;
      cnt1_ff <= 32'h0;
    end else begin
      cnt2_ff <= port2_phy_reset_o ? cnt2_ff + 32'h1 : 32'h0;
      cnt1_ff <= port1_phy_reset_o ? cnt1_ff + 32'h1 : 32'h0;
    end
  end
  // Timer enable as last written
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      en_ff <= 1'b0;
    end else if (req_i.wr && req_i.be[3] &&
                 req_i.addr == misc_regs_pkg::TIMER_CONFIG_OFS) begin
      en_ff <= req_i.wdata[29];
    end
  end
  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);
  property p_rvalid; req_i.rd |=> rvalid_o; endproperty
  a_rvalid: assert property (p_rvalid)
    else $error("read not answered");
  property p_p2_min; $fell(port2_phy_reset_o) |-> cnt2_ff >= PHY_HOLD;
  endproperty
  a_p2_min: assert property (p_p2_min)
    else $error("port 2 reset too short");
  property p_p2_max; cnt2_ff <= PHY_HOLD + 2; endproperty
  a_p2_max: assert property (p_p2_max)
    else $error("port 2 reset restarted or stuck");
  property p_p1_min; $fell(port1_phy_reset_o) |-> cnt1_ff >= PHY_HOLD;
  endproperty
  a_p1_min: assert property (p_p1_min)
    else $error("port 1 reset too short");
  property p_p2_go;
    ctl_wr && req_i.wdata[2] && !port2_phy_reset_o |=> port2_phy_reset_o;
  endproperty
  a_p2_go: assert property (p_p2_go)
    else $error("port 2 reset not started");
  property p_loader;
    req_i.wr && req_i.from_loader && !port1_phy_reset_o |=>
      !port1_phy_reset_o;
  endproperty
  a_loader: assert property (p_loader)
    else $error("loader started port 1 reset");
  property p_vphy;
    $rose(virtual_phy_reset_o) |->
      virtual_phy_reset_o [*4] ##1 !virtual_phy_reset_o;
  endproperty
  a_vphy: assert property (p_vphy)
    else $error("virtual reset pulse length wrong");
  property p_halt; !en_ff && !$past(en_ff) |-> !timer_irq_o; endproperty
  a_halt: assert property (p_halt)
    else $error("event while timer halted");
endmodule
`default_nettype wire

// File: verification/tb_top.sv
// Self-checking bench for the timer and soft reset register block.
// Assumes the package is compiled first; drives ports directly.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  localparam int HOLD = 20;
  typedef struct {logic [11:0] ad; logic [31:0] ex;} row_type;
  logic                       clk_i = 1'b0;
  logic                       arst_n_i = 1'b0;
  misc_regs_pkg::reg_req_type req_i = '0;
  logic [31:0]                rdata_o;
  logic                       rvalid_o;
  logic                       timer_irq_o;
  logic                       virtual_phy_reset_o;
  logic                       port2_phy_reset_o;
  logic                       port1_phy_reset_o;
  int                         error_cnt = 0;
  int                         checks = 0;
  int                         cyc = 0;
  int                         n;
  logic [31:0]                a;
  logic [31:0]                b;
  row_type rows[4] = '{'{12'h08C, 32'h0000FFFF}, '{12'h090, 32'h0000FFFF},
                       '{12'h1F8, 32'h00000000}, '{12'h0A0, 32'h00000000}};
  // Clock at 8 ns period
  always #4 clk_i = ~clk_i;
  gp_timer_freerun_soft_reset_control #(.PHY_HOLD(HOLD)) gp_timer_freerun_soft_reset_control_i (
    .clk_i(clk_i), .arst_n_i(arst_n_i), .req_i(req_i), .rdata_o(rdata_o),
    .rvalid_o(rvalid_o), .timer_irq_o(timer_irq_o),
    .virtual_phy_reset_o(virtual_phy_reset_o),
    .port2_phy_reset_o(port2_phy_reset_o),
    .port1_phy_reset_o(port1_phy_reset_o));
  // Compare and count
  task automatic compare(input logic [31:0] seen, exp, input string nm);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  // Register read, data taken when answered
  task automatic rd(input logic [11:0] ad, output logic [31:0] d);
    @(posedge clk_i);
    #1 req_i.rd = 1'b1;
    req_i.addr = ad;
    @(posedge clk_i);
    #1 req_i.rd = 1'b0;
    compare({31'h0, rvalid_o}, 32'h1, "rvalid");
    d = rdata_o;
  endtask
  // Register write of a whole word
  task automatic wr(input logic [11:0] ad, input logic [31:0] d,
                    input logic ldr);
    @(posedge clk_i);
    #1 req_i.wr = 1'b1;
    req_i.addr = ad;
    req_i.wdata = d;
    req_i.be = 4'hF;
    req_i.from_loader = ldr;
    @(posedge clk_i);
    #1 req_i.wr = 1'b0;
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // Hang guard
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 3000) begin
      error_cnt++;
      give_verdict();
    end
  end
  initial begin
    repeat (10) @(posedge clk_i);
    #1 arst_n_i = 1'b1;
    foreach (rows[i]) begin
      rd(rows[i].ad, a);
      compare(a, rows[i].ex, "reset value");
    end
    $display("reset values done");
    rd(12'h09C, a);
    repeat (48) @(posedge clk_i);
    rd(12'h09C, b);
    compare(b - a, 32'hA, "tick step");
    $display("tick counter done");
    wr(12'h08C, 32'h20000003, 1'b0);
    n = 0;
    while (timer_irq_o !== 1'b1 && n < 50) begin
      @(posedge clk_i);
      #1 n++;
    end
    n = 0;
    repeat (40) begin
      @(posedge clk_i);
      #1 if (timer_irq_o === 1'b1) n++;
    end
    compare(n, 32'hA, "event count");
    wr(12'h08C, 32'h00000003, 1'b0);
    rd(12'h08C, a);
    compare(a, 32'h0000FFFF, "preload preset");
    rd(12'h090, a);
    repeat (10) @(posedge clk_i);
    rd(12'h090, b);
    compare(b, a, "halted count");
    wr(12'h08C, 32'h20000100, 1'b0);
    rd(12'h090, a);
    compare(a > 32'hF9 && a <= 32'h100, 1'b1, "start count");
    repeat (48) @(posedge clk_i);
    rd(12'h090, b);
    compare(a - b, 32'h32, "count down");
    $display("timer done");
    wr(12'h1F8, 32'h00000004, 1'b0);
    rd(12'h1F8, a);
    compare(a, 32'h4, "port 2 bit");
    wr(12'h1F8, 32'h00000004, 1'b0);
    repeat (HOLD + 5) @(posedge clk_i);
    rd(12'h1F8, a);
    compare(a, 32'h0, "self clear");
    wr(12'h1F8, 32'h00000002, 1'b0);
    wr(12'h1F8, 32'h0000000C, 1'b1);
    rd(12'h1F8, a);
    compare(a, 32'h2, "loader ignored");
    wr(12'h1F8, 32'h00000008, 1'b0);
    compare(virtual_phy_reset_o, 1'b1, "virtual reset");
    repeat (HOLD + 5) @(posedge clk_i);
    #1 compare(virtual_phy_reset_o, 1'b0, "virtual clear");
    rd(12'h1F8, a);
    compare(a, 32'h0, "all clear");
    $display("soft resets done");
    arst_n_i = 1'b0;
    repeat (2) @(posedge clk_i);
    #1 arst_n_i = 1'b1;
    rd(12'h09C, a);
    compare(a < 32'h8, 1'b1, "tick cleared");
    $display("second reset done");
    give_verdict();
  end
endmodule
// Attach the port checker
bind gp_timer_freerun_soft_reset_control misc_regs_checker #(.PHY_HOLD(PHY_HOLD))
  misc_regs_checker_i (.clk_i(clk_i), .arst_n_i(arst_n_i), .req_i(req_i),
  .rdata_o(rdata_o), .rvalid_o(rvalid_o), .timer_irq_o(timer_irq_o),
  .virtual_phy_reset_o(virtual_phy_reset_o),
  .port2_phy_reset_o(port2_phy_reset_o),
  .port1_phy_reset_o(port1_phy_reset_o));
`default_nettype wire
